// >>> design/cfbr_pkg.sv
// package: register map, fields, modes and id carrier for the can filter and bus-lock block
//
// Contract
// - extended mask 0 ignores bit, 1 compares
// - standard mask 0 ignores bit, 1 compares
// - 32 dominant bits in operation set flag
// - re-arm after flag clear then recessive bit
// - re-arm after clear, reset mode, operation
// - forced recovery write 1 leaves bus-off
// - bit timing from peripheral bus clock
// - unimplemented bits hold nothing, read zero
// - no halt while bus locked dominant
package cfbr_pkg;

  // bus geometry
  localparam int unsigned    ADDR_W        = 8;
  localparam int unsigned    DATA_W        = 32;

  // register byte offsets
  localparam logic [7:0]     CTRL_OFF      = 8'h00;  // can_control_reg
  localparam logic [7:0]     ERR_OFF       = 8'h04;  // can_error_flag_reg
  localparam logic [7:0]     MASK_STD_OFF  = 8'h08;  // standard mask + ide compare
  localparam logic [7:0]     MASK_EXT_OFF  = 8'h0c;  // extended mask
  localparam logic [7:0]     CODE_STD_OFF  = 8'h10;  // standard code + ide
  localparam logic [7:0]     CODE_EXT_OFF  = 8'h14;  // extended code
  localparam logic [7:0]     STAT_OFF      = 8'h18;  // mode, bus-off, last accept
  localparam logic [7:0]     IRQ_STAT_OFF  = 8'h1c;  // sticky events, read clears
  localparam logic [7:0]     IRQ_MASK_OFF  = 8'h20;  // event enables
  localparam logic [7:0]     PRESC_OFF     = 8'h24;  // quanta prescaler

  // control register fields
  localparam int unsigned    CTRL_MODE_LSB = 0;
  localparam int unsigned    CTRL_FORCED_BUSOFF_RECOVERY_BIT = 4;
  // error flag register fields
  localparam int unsigned    ERR_FLAG_BIT  = 0;
  localparam int unsigned    ERR_LOCK_BIT  = 1;
  // status register fields
  localparam int unsigned    STAT_BOFF_BIT = 2;
  localparam int unsigned    STAT_ACC_BIT  = 3;
  // id field widths, ide rides at bit 11 of the std words
  localparam int unsigned    STD_W         = 11;
  localparam int unsigned    EXT_W         = 18;
  localparam int unsigned    IDE_BIT       = 11;

  // interrupt event bits
  localparam int unsigned    IRQ_W         = 3;
  localparam int unsigned    IRQ_LOCK      = 0;
  localparam int unsigned    IRQ_ACCEPT    = 1;
  localparam int unsigned    IRQ_RECOVER   = 2;

  // timing
  localparam int unsigned    LOCK_BITS     = 32;  // dominant run that means lock
  localparam int unsigned    TQ_PER_BIT    = 8;   // quanta per bit time
  localparam logic [7:0]     PRESC_RST     = 8'h00;

  // axi responses
  localparam logic [1:0]     RESP_OKAY     = 2'b00;
  localparam logic [1:0]     RESP_SLVERR   = 2'b10;

  // operating modes
  typedef enum logic [1:0] {
    CFBR_OPER  = 2'b00,
    CFBR_RESET = 2'b01,
    CFBR_HALT  = 2'b10
  } cfbr_mode_type;

  // received identifier, also used for code and mask sets
  typedef struct packed {
    logic             ide;
    logic [STD_W-1:0] std_id;
    logic [EXT_W-1:0] ext_id;
  } cfbr_id_type;

endpackage

// >>> design/cfbr_accept_filter.sv
// acceptance filter: masked compare of a received id against the code set
`timescale 1ns/1ps
module cfbr_accept_filter (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  valid_i,
  input  wire cfbr_pkg::cfbr_id_type id_i,
  input  wire cfbr_pkg::cfbr_id_type code_i,
  input  wire cfbr_pkg::cfbr_id_type mask_i,
  output logic                       done_o,
  output logic                       accept_o
);
  import cfbr_pkg::*;

  logic done_q;    // result strobe
  logic done_d;
  logic acc_q;     // last verdict
  logic acc_d;
  logic std_ok;    // standard part matches
  logic ext_ok;    // extended part matches or unused
  logic ide_ok;    // frame format matches

  // compare only where the mask holds a 1
  always_comb begin
    std_ok = ((id_i.std_id ^ code_i.std_id) & mask_i.std_id) == '0;
    ext_ok = !id_i.ide || (((id_i.ext_id ^ code_i.ext_id) & mask_i.ext_id) == '0);
    ide_ok = !mask_i.ide || (id_i.ide == code_i.ide);
    done_d = valid_i;
    acc_d  = valid_i ? (std_ok && ext_ok && ide_ok) : acc_q;
  end

  // verdict register, held until the next id
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      acc_q  <= 1'b0;
    end else begin
      done_q <= done_d;
      acc_q  <= acc_d;
    end
  end

  assign done_o   = done_q;
  assign accept_o = acc_q;

endmodule

// >>> design/cfbr_core.sv
// top: axi4-lite registers, bus-lock detector, mode control, bus-off recovery
`timescale 1ns/1ps
module cfbr_core #(
  parameter int unsigned TQ_BIT = cfbr_pkg::TQ_PER_BIT  // quanta per bit
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // axi4-lite slave
  input  wire logic [cfbr_pkg::ADDR_W-1:0]   s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [cfbr_pkg::DATA_W-1:0]   s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [cfbr_pkg::ADDR_W-1:0]   s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [cfbr_pkg::DATA_W-1:0]        s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  // can bus receive pin, async
  input  wire logic                          can_rx_i,
  // received identifier from the frame decoder
  input  wire logic                          rx_id_valid_i,
  input  wire cfbr_pkg::cfbr_id_type         rx_id_i,
  output logic                               accept_valid_o,
  output logic                               accept_o,
  // bus-off from the error counters
  input  wire logic                          busoff_enter_i,
  input  wire logic                          busoff_exit_i,
  output logic                               busoff_o,
  output logic                               busoff_recover_o,
  // status
  output cfbr_pkg::cfbr_mode_type            mode_o,
  output logic                               bus_lock_flag_o,
  output logic                               bit_tick_o,
  output logic                               irq_o
);
  import cfbr_pkg::*;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // word-aligned offset of a byte address
  function automatic logic [7:0] word_of(input logic [ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // ---------------- axi channel state ----------------
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;  // held write address
  logic              aw_vld_q, aw_vld_d;    // write address captured
  logic [31:0]       w_data_q, w_data_d;    // held write data
  logic [3:0]        w_strb_q, w_strb_d;    // held strobes
  logic              w_vld_q, w_vld_d;      // write data captured
  logic              bvalid_q, bvalid_d;    // write response pending
  logic [1:0]        bresp_q, bresp_d;      // write response code
  logic              rvalid_q, rvalid_d;    // read response pending
  logic [31:0]       rdata_q, rdata_d;      // read data
  logic [1:0]        rresp_q, rresp_d;      // read response code
  logic              wr_fire;               // write applied this cycle
  logic              rd_fire;               // read taken this cycle
  logic [7:0]        wr_off;                // decoded write offset
  logic [7:0]        rd_off;                // decoded read offset
  logic [31:0]       rd_word;               // read mux result
  logic              rd_hit;                // read offset mapped
  logic              wr_hit;                // write offset mapped

  // ---------------- registers ----------------
  cfbr_mode_type     mode_req_q, mode_req_d;  // requested mode
  cfbr_id_type       mask_q, mask_d;          // compare mask
  cfbr_id_type       code_q, code_d;          // compare code
  logic [7:0]        presc_q, presc_d;        // quanta prescaler
  logic [IRQ_W-1:0]  irq_stat_q, irq_stat_d;  // sticky events
  logic [IRQ_W-1:0]  irq_mask_q, irq_mask_d;  // event enables
  logic              forced_busoff_recovery_q, forced_busoff_recovery_d;          // forced recovery pulse
  logic              flag_clr;                // software wrote 0 to flag

  // ---------------- bit timing and lock ----------------
  logic              rx_meta_q, rx_sync_q;    // pin synchroniser
  logic [7:0]        tq_cnt_q, tq_cnt_d;      // clocks within a quantum
  logic [3:0]        tq_idx_q, tq_idx_d;      // quantum within a bit
  logic              tick;                    // bit sample point
  logic [5:0]        dom_cnt_q, dom_cnt_d;    // dominant run length
  logic              flag_q, flag_d;          // bus_lock_flag
  logic              armed_q, armed_d;        // detector may fire
  logic              cleared_q, cleared_d;    // flag cleared since firing
  logic              seen_rst_q, seen_rst_d;  // reset mode seen after clear
  logic              lock_evt;                // lock detected now
  logic              lock_active;             // dominant run still >= 32
  logic              in_oper;                 // operation mode

  // ---------------- mode and bus-off ----------------
  cfbr_mode_type     mode_q, mode_d;          // current mode
  logic              boff_q, boff_d;          // bus-off state
  logic              recover_evt;             // left bus-off
  logic              acc_done;                // filter verdict strobe
  logic              acc_res;                 // filter verdict
  logic              acc_last_q, acc_last_d;  // last verdict for status

  // axi handshakes: address and data captured independently
  always_comb begin
    s_axi_awready_o = !aw_vld_q && !bvalid_q;
    s_axi_wready_o  = !w_vld_q && !bvalid_q;
    s_axi_arready_o = !rvalid_q;
    wr_fire         = aw_vld_q && w_vld_q && !bvalid_q;
    rd_fire         = s_axi_arvalid_i && !rvalid_q;
    wr_off          = word_of(aw_addr_q);
    rd_off          = word_of(s_axi_araddr_i);
  end

  // read mux; unimplemented bits are constant zero
  always_comb begin
    rd_word = 32'h0;
    rd_hit  = 1'b1;
    unique case (rd_off)
      CTRL_OFF:     rd_word[1:0] = mode_req_q;
      ERR_OFF: begin
        rd_word[ERR_FLAG_BIT] = flag_q;
        rd_word[ERR_LOCK_BIT] = lock_active;
      end
      MASK_STD_OFF: rd_word[IDE_BIT:0] = {mask_q.ide, mask_q.std_id};
      MASK_EXT_OFF: rd_word[EXT_W-1:0] = mask_q.ext_id;
      CODE_STD_OFF: rd_word[IDE_BIT:0] = {code_q.ide, code_q.std_id};
      CODE_EXT_OFF: rd_word[EXT_W-1:0] = code_q.ext_id;
      STAT_OFF: begin
        rd_word[1:0]          = mode_q;
        rd_word[STAT_BOFF_BIT] = boff_q;
        rd_word[STAT_ACC_BIT]  = acc_last_q;
      end
      IRQ_STAT_OFF: rd_word[IRQ_W-1:0] = irq_stat_q;
      IRQ_MASK_OFF: rd_word[IRQ_W-1:0] = irq_mask_q;
      PRESC_OFF:    rd_word[7:0] = presc_q;
      default:      rd_hit = 1'b0;
    endcase
  end

  // axi next state
  always_comb begin
    aw_addr_d = aw_addr_q;
    aw_vld_d  = aw_vld_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    w_vld_d   = w_vld_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_addr_d = s_axi_awaddr_i;
      aw_vld_d  = 1'b1;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_data_d = s_axi_wdata_i;
      w_strb_d = s_axi_wstrb_i;
      w_vld_d  = 1'b1;
    end
    if (wr_fire) begin
      aw_vld_d = 1'b0;
      w_vld_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
  end

  // axi registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_addr_q <= '0;
      aw_vld_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      w_vld_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_addr_q <= aw_addr_d;
      aw_vld_q  <= aw_vld_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      w_vld_q   <= w_vld_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // register writes and interrupt bookkeeping
  always_comb begin
    logic [31:0] nv;
    nv         = apply_strb(32'h0, w_data_q, w_strb_q);
    mode_req_d = mode_req_q;
    mask_d     = mask_q;
    code_d     = code_q;
    presc_d    = presc_q;
    irq_mask_d = irq_mask_q;
    forced_busoff_recovery_d     = 1'b0;
    flag_clr   = 1'b0;
    wr_hit     = 1'b1;
    unique case (wr_off)
      CTRL_OFF: if (wr_fire && w_strb_q[0]) begin
        // code 11 is not a mode; such a write leaves the request alone
        if (nv[1:0] != 2'b11) begin
          mode_req_d = cfbr_mode_type'(nv[1:0]);
        end
        forced_busoff_recovery_d = nv[CTRL_FORCED_BUSOFF_RECOVERY_BIT];
      end
      ERR_OFF: if (wr_fire && w_strb_q[0]) begin
        flag_clr = !nv[ERR_FLAG_BIT];
      end
      MASK_STD_OFF: if (wr_fire) begin
        nv = apply_strb({20'h0, mask_q.ide, mask_q.std_id}, w_data_q, w_strb_q);
        {mask_d.ide, mask_d.std_id} = nv[IDE_BIT:0];
      end
      MASK_EXT_OFF: if (wr_fire) begin
        nv = apply_strb({14'h0, mask_q.ext_id}, w_data_q, w_strb_q);
        mask_d.ext_id = nv[EXT_W-1:0];
      end
      CODE_STD_OFF: if (wr_fire) begin
        nv = apply_strb({20'h0, code_q.ide, code_q.std_id}, w_data_q, w_strb_q);
        {code_d.ide, code_d.std_id} = nv[IDE_BIT:0];
      end
      CODE_EXT_OFF: if (wr_fire) begin
        nv = apply_strb({14'h0, code_q.ext_id}, w_data_q, w_strb_q);
        code_d.ext_id = nv[EXT_W-1:0];
      end
      IRQ_MASK_OFF: if (wr_fire) begin
        irq_mask_d = nv[IRQ_W-1:0];
      end
      PRESC_OFF: if (wr_fire) begin
        presc_d = nv[7:0];
      end
      STAT_OFF, IRQ_STAT_OFF: ;  // read-only, write ignored
      default: wr_hit = 1'b0;
    endcase
    // a set in the cycle of the clearing read survives
    irq_stat_d = irq_stat_q & ~((rd_fire && rd_off == IRQ_STAT_OFF) ? {IRQ_W{1'b1}} : '0);
    irq_stat_d[IRQ_LOCK]    = irq_stat_d[IRQ_LOCK] | lock_evt;
    irq_stat_d[IRQ_ACCEPT]  = irq_stat_d[IRQ_ACCEPT] | (acc_done & acc_res);
    irq_stat_d[IRQ_RECOVER] = irq_stat_d[IRQ_RECOVER] | recover_evt;
  end

  // register file
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_req_q <= CFBR_RESET;
      mask_q     <= '0;
      code_q     <= '0;
      presc_q    <= PRESC_RST;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      forced_busoff_recovery_q     <= 1'b0;
    end else begin
      mode_req_q <= mode_req_d;
      mask_q     <= mask_d;
      code_q     <= code_d;
      presc_q    <= presc_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      forced_busoff_recovery_q     <= forced_busoff_recovery_d;
    end
  end

  // bit timing off the bus clock, and the lock detector
  always_comb begin
    in_oper     = (mode_q == CFBR_OPER);
    tick        = (tq_cnt_q == presc_q) && (tq_idx_q == 4'(TQ_BIT - 1));
    tq_cnt_d    = (tq_cnt_q == presc_q) ? 8'h00 : tq_cnt_q + 8'h01;
    tq_idx_d    = tq_idx_q;
    if (tq_cnt_q == presc_q) begin
      tq_idx_d = tick ? 4'h0 : tq_idx_q + 4'h1;
    end
    lock_active = (dom_cnt_q == 6'(LOCK_BITS));
    dom_cnt_d   = dom_cnt_q;
    if (!in_oper) begin
      dom_cnt_d = 6'h00;
    end else if (tick) begin
      // saturate so a long lock never wraps into a second event
      dom_cnt_d = rx_sync_q ? 6'h00 : (lock_active ? dom_cnt_q : dom_cnt_q + 6'h01);
    end
    lock_evt   = in_oper && tick && !rx_sync_q && armed_q &&
                 (dom_cnt_q == 6'(LOCK_BITS - 1));
    flag_d     = lock_evt || (flag_q && !flag_clr);
    cleared_d  = cleared_q || (flag_q && flag_clr);
    seen_rst_d = seen_rst_q || (cleared_q && mode_q == CFBR_RESET);
    armed_d    = armed_q;
    if (lock_evt) begin
      armed_d    = 1'b0;
      cleared_d  = 1'b0;
      seen_rst_d = 1'b0;
    end else if (!armed_q && cleared_q &&
                 ((in_oper && tick && rx_sync_q) || (in_oper && seen_rst_q))) begin
      armed_d    = 1'b1;
      cleared_d  = 1'b0;
      seen_rst_d = 1'b0;
    end
  end

  // timing and lock registers; pin passes two flops first
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_meta_q  <= 1'b1;
      rx_sync_q  <= 1'b1;
      tq_cnt_q   <= 8'h00;
      tq_idx_q   <= 4'h0;
      dom_cnt_q  <= 6'h00;
      flag_q     <= 1'b0;
      armed_q    <= 1'b1;
      cleared_q  <= 1'b0;
      seen_rst_q <= 1'b0;
    end else begin
      rx_meta_q  <= can_rx_i;
      rx_sync_q  <= rx_meta_q;
      tq_cnt_q   <= tq_cnt_d;
      tq_idx_q   <= tq_idx_d;
      dom_cnt_q  <= dom_cnt_d;
      flag_q     <= flag_d;
      armed_q    <= armed_d;
      cleared_q  <= cleared_d;
      seen_rst_q <= seen_rst_d;
    end
  end

  // mode control and bus-off
  always_comb begin
    mode_d = mode_q;
    unique case (mode_req_q)
      CFBR_RESET: mode_d = CFBR_RESET;
      CFBR_OPER:  mode_d = CFBR_OPER;
      // a locked bus keeps the block in operation; only reset leaves
      CFBR_HALT:  mode_d = lock_active ? mode_q : CFBR_HALT;
    endcase
    recover_evt = boff_q && (busoff_exit_i || forced_busoff_recovery_q) && !busoff_enter_i;
    boff_d      = busoff_enter_i || (boff_q && !busoff_exit_i && !forced_busoff_recovery_q);
    acc_last_d  = acc_done ? acc_res : acc_last_q;
  end

  // mode and bus-off registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q     <= CFBR_RESET;
      boff_q     <= 1'b0;
      acc_last_q <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      boff_q     <= boff_d;
      acc_last_q <= acc_last_d;
    end
  end

  // masked compare of received ids
  cfbr_accept_filter u_filter (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .valid_i  (rx_id_valid_i),
    .id_i     (rx_id_i),
    .code_i   (code_q),
    .mask_i   (mask_q),
    .done_o   (acc_done),
    .accept_o (acc_res)
  );

  // outputs
  assign s_axi_bvalid_o   = bvalid_q;
  assign s_axi_bresp_o    = bresp_q;
  assign s_axi_rvalid_o   = rvalid_q;
  assign s_axi_rdata_o    = rdata_q;
  assign s_axi_rresp_o    = rresp_q;
  assign accept_valid_o   = acc_done;
  assign accept_o         = acc_res;
  assign busoff_o         = boff_q;
  assign busoff_recover_o = forced_busoff_recovery_q;
  assign mode_o           = mode_q;
  assign bus_lock_flag_o  = flag_q;
  assign bit_tick_o       = tick;
  assign irq_o            = |(irq_stat_q & irq_mask_q);

endmodule

// >>> bench/cfbr_bus_node.sv
// far-side can node model: pulls the bus dominant on command
`timescale 1ns/1ps
module cfbr_bus_node (
  input  wire logic dominant_i,
  input  wire logic clk_i,
  output logic      can_rx_o
);
  // released bus floats back to recessive through the termination
  always @(posedge clk_i) can_rx_o <= !dominant_i;
endmodule

// >>> bench/cfbr_core_monitor.sv
// checker: bus handshakes, lock flag, bus-off recovery and bit tick at core ports
`timescale 1ns/1ps
module cfbr_core_monitor
  import cfbr_pkg::*;
#(
  parameter int unsigned TQ_BIT = 8
) (
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  input wire logic          s_axi_awvalid_i,
  input wire logic          s_axi_awready_o,
  input wire logic          s_axi_wvalid_i,
  input wire logic          s_axi_wready_o,
  input wire logic          s_axi_bvalid_o,
  input wire logic          s_axi_bready_i,
  input wire logic          s_axi_arvalid_i,
  input wire logic          s_axi_arready_o,
  input wire logic [31:0]   s_axi_rdata_o,
  input wire logic          s_axi_rvalid_o,
  input wire logic          s_axi_rready_i,
  input wire logic          rx_id_valid_i,
  input wire logic          accept_valid_o,
  input wire logic          busoff_enter_i,
  input wire logic          busoff_o,
  input wire logic          busoff_recover_o,
  input wire cfbr_mode_type mode_o,
  input wire logic          bus_lock_flag_o,
  input wire logic          bit_tick_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // both write channels taken at one edge
  sequence s_wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_o)
    else $error("read response late");
  a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data moved");
  a_busy_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while busy");
  a_rd_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
  a_accept_next: assert property (rx_id_valid_i |=> accept_valid_o)
    else $error("filter verdict late");
  a_lock_oper: assert property ($rose(bus_lock_flag_o) |-> $past(mode_o) == CFBR_OPER)
    else $error("lock flag outside operation");
  a_flag_clear: assert property ($fell(bus_lock_flag_o) |-> $rose(s_axi_bvalid_o))
    else $error("lock flag fell without a write");
  a_recover_exit: assert property (busoff_recover_o && !busoff_enter_i |-> ##[0:2] !busoff_o)
    else $error("forced recovery left bus-off set");
  a_tick_apart: assert property (bit_tick_o && TQ_BIT > 1 |=> !bit_tick_o)
    else $error("bit ticks too close");
endmodule
bind cfbr_core cfbr_core_monitor #(.TQ_BIT(TQ_BIT)) cfbr_core_monitor_i (
  .clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .rx_id_valid_i, .accept_valid_o, .busoff_enter_i,
  .busoff_o, .busoff_recover_o, .mode_o, .bus_lock_flag_o, .bit_tick_o);

// >>> bench/cfbr_core_test.sv
// bench: registers, filter, lock detector, modes and bus-off recovery
`timescale 1ns/1ps
module cfbr_core_test;
  import cfbr_pkg::*;
  logic clk_i, rst_n_i, awv, wv, bre, arv, rre, dom, idv, ben, bex;
  logic awr, wrr, bv, arr, rv, can_rx, accv, acc, boff, flag, tick, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, rd_v;
  logic [1:0] bresp, rresp, rsp;
  cfbr_mode_type mode;
  cfbr_id_type id, nid, cd, mk;
  int n_errors = 0, n_tests = 0, seed = 4492, cyc = 0, k, t;
  // two quanta per bit keeps 32-bit lock runs short
  cfbr_core #(.TQ_BIT(2)) cfbr_core_i (.clk_i, .rst_n_i, .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .can_rx_i(can_rx), .rx_id_valid_i(idv), .rx_id_i(id), .accept_valid_o(accv),
    .accept_o(acc), .busoff_enter_i(ben), .busoff_exit_i(bex), .busoff_o(boff),
    .busoff_recover_o(), .mode_o(mode), .bus_lock_flag_o(flag), .bit_tick_o(tick), .irq_o(irq));
  cfbr_bus_node cfbr_bus_node_i (.dominant_i(dom), .clk_i, .can_rx_o(can_rx));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // write: both channels offered, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    chk("bresp", bresp, RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd_v = rdata; rsp = rresp; rre <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic exp_acc(cfbr_id_type i, cfbr_id_type c, cfbr_id_type m);
    return (((i.std_id ^ c.std_id) & m.std_id) == '0)
      && (!i.ide || (((i.ext_id ^ c.ext_id) & m.ext_id) == '0))
      && (!m.ide || (i.ide == c.ide));
  endfunction
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well above the eleven hundred or so cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    rst_n_i = 1'b0; {awv, wv, bre, arv, rre, dom, idv, ben, bex} = '0;
    awa = '0; ara = '0; wd = '0; id = '0;
    idle(10);
    rst_n_i <= 1'b1;
    wr(CTRL_OFF, 32'hff); rd(CTRL_OFF); chk("ctrl b7 b4", rd_v & 32'h90, 0);
    wr(ERR_OFF, 32'hff); rd(ERR_OFF); chk("err b6-b5", rd_v & 32'h60, 0);
    rd(8'h40); chk("unmapped", rd_v, 0);
    chk("slverr", rsp, RESP_SLVERR);
    // one flipped bit a round, masked in or out at random
    for (k = 0; k < 30; k++) begin
      t = $random(seed); nid = t[29:0]; t = $random(seed); mk = t[29:0];
      cd = nid ^ (30'h1 << k);
      wr(MASK_STD_OFF, {20'h0, mk.ide, mk.std_id}); wr(MASK_EXT_OFF, {14'h0, mk.ext_id});
      wr(CODE_STD_OFF, {20'h0, cd.ide, cd.std_id}); wr(CODE_EXT_OFF, {14'h0, cd.ext_id});
      @(posedge clk_i); id <= nid; idv <= 1'b1;
      @(posedge clk_i); idv <= 1'b0;
      @(negedge clk_i); chk("accept", {accv, acc}, {1'b1, exp_acc(nid, cd, mk)});
    end
    wr(IRQ_MASK_OFF, 32'h7); rd(IRQ_STAT_OFF);
    wr(CTRL_OFF, 0); dom <= 1'b1; idle(100); chk("lock set", {flag, irq}, 2'b11);
    wr(CTRL_OFF, 32'h2); idle(2); chk("halt refused", mode, CFBR_OPER);
    wr(ERR_OFF, 1); idle(2); chk("w1 keeps", flag, 1);
    wr(ERR_OFF, 0); idle(100); chk("no rearm", flag, 0);
    dom <= 1'b0; idle(10); chk("halt free", mode, CFBR_HALT);
    wr(CTRL_OFF, 0); dom <= 1'b1; idle(100); chk("rearm rec", flag, 1);
    wr(ERR_OFF, 0); wr(CTRL_OFF, 1); wr(CTRL_OFF, 0);
    idle(100); chk("rearm reset", flag, 1);
    wr(CTRL_OFF, 1); idle(2); chk("reset ok", mode, CFBR_RESET);
    dom <= 1'b0;
    rd(IRQ_STAT_OFF); chk("lock event", rd_v[0], 1);
    rd(IRQ_STAT_OFF); chk("read clears", {rd_v[0], irq}, 0);
    ben <= 1'b1; idle(1); ben <= 1'b0;
    wr(CTRL_OFF, 1); idle(3); chk("forced_busoff_recovery 0 idle", boff, 1);
    wr(CTRL_OFF, 32'h11); idle(3); chk("forced_busoff_recovery 1", boff, 0);
    rd(IRQ_STAT_OFF); chk("recover event", rd_v[2], 1);
    // slower bit: prescaler 1 gives four clocks per bit
    wr(PRESC_OFF, 1); idle(8); t = 0;
    repeat (40) begin
      @(posedge clk_i);
      t += tick;
    end
    chk("ticks", t, 10);
    complete_run;
  end
endmodule
